// ---- hw/cppi_defines.svh ----
`ifndef CPPI_DEFINES_SVH
`define CPPI_DEFINES_SVH

// Step format selector codes.
`define CPPI_FMT_STEP_DIR_POS  4'h0
`define CPPI_FMT_FWD_REV_POS   4'h1
`define CPPI_FMT_QUAD1_POS     4'h2
`define CPPI_FMT_QUAD2_POS     4'h3
`define CPPI_FMT_QUAD4_POS     4'h4
`define CPPI_FMT_STEP_DIR_NEG  4'h5
`define CPPI_FMT_FWD_REV_NEG   4'h6
`define CPPI_FMT_QUAD1_NEG     4'h7
`define CPPI_FMT_QUAD2_NEG     4'h8
`define CPPI_FMT_QUAD4_NEG     4'h9
`define CPPI_FMT_RESET         4'h1

// Clear trigger selector codes.
`define CPPI_CLR_LEVEL_HIGH    2'h0
`define CPPI_CLR_RISING        2'h1
`define CPPI_CLR_LEVEL_LOW     2'h2
`define CPPI_CLR_FALLING       2'h3

// Timing.
`define CPPI_CLK_MHZ           200
`define CPPI_CLR_MIN_US        20
`define CPPI_CLR_MIN_CYC       (`CPPI_CLR_MIN_US * `CPPI_CLK_MHZ)
`define CPPI_WAKE_HOLD_S       3

`endif

// ---- hw/cppi_pkg.sv ----
package cppi_pkg;

  typedef enum logic [1:0] {
    CPPI_ST_OFF     = 2'b00,
    CPPI_ST_SEND    = 2'b01,
    CPPI_ST_WAIT_OK = 2'b10,
    CPPI_ST_READY   = 2'b11
  } cppi_wake_e;

  typedef logic [3:0] cppi_fmt_t;

endpackage : cppi_pkg

// ---- hw/cppi_step_decode.sv ----
`include "cppi_defines.svh"

// Turns the two synchronised command lines into forward and reverse count pulses.
module cppi_step_decode
  import cppi_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire cppi_fmt_t fmt,
  input  wire logic      line_a,
  input  wire logic      line_b,
  output logic           fwd_cnt,
  output logic           rev_cnt
);

  logic a_reg;
  logic b_reg;
  logic neg;
  logic a;
  logic b;
  logic a_prev;
  logic b_prev;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic dir_q;

  assign neg    = (fmt >= `CPPI_FMT_STEP_DIR_NEG);
  assign a      = line_a ^ neg;
  assign b      = line_b ^ neg;
  assign a_prev = a_reg ^ neg;
  assign b_prev = b_reg ^ neg;
  assign a_rise = a & ~a_prev;
  assign a_fall = ~a & a_prev;
  assign b_rise = b & ~b_prev;
  assign b_fall = ~b & b_prev;
  // Forward when A leads B.
  assign dir_q  = (a_rise & ~b) | (a_fall & b) | (b_rise & a) | (b_fall & ~a);

  // Sampling goes on through reset so that a line idling high gives no false edge at release.
  always_ff @(posedge clk) begin
    if (rst) begin
      a_reg <= line_a;
      b_reg <= line_b;
    end else begin
      a_reg <= line_a;
      b_reg <= line_b;
    end
  end

  always_comb begin
    fwd_cnt = 1'b0;
    rev_cnt = 1'b0;
    unique case (fmt)
      `CPPI_FMT_STEP_DIR_POS, `CPPI_FMT_STEP_DIR_NEG: begin
        fwd_cnt = a_rise & b;
        rev_cnt = a_rise & ~b;
      end
      `CPPI_FMT_FWD_REV_POS, `CPPI_FMT_FWD_REV_NEG: begin
        fwd_cnt = b_rise;
        rev_cnt = a_rise;
      end
      `CPPI_FMT_QUAD1_POS, `CPPI_FMT_QUAD1_NEG: begin
        fwd_cnt = a_rise & ~b;
        rev_cnt = a_fall & ~b;
      end
      `CPPI_FMT_QUAD2_POS, `CPPI_FMT_QUAD2_NEG: begin
        fwd_cnt = (a_rise | a_fall) & dir_q;
        rev_cnt = (a_rise | a_fall) & ~dir_q;
      end
      `CPPI_FMT_QUAD4_POS, `CPPI_FMT_QUAD4_NEG: begin
        fwd_cnt = (a_rise | a_fall | b_rise | b_fall) & dir_q;
        rev_cnt = (a_rise | a_fall | b_rise | b_fall) & ~dir_q;
      end
      default: begin
        fwd_cnt = 1'b0;
        rev_cnt = 1'b0;
      end
    endcase
  end

endmodule : cppi_step_decode

// ---- hw/cppi_top.sv ----
// Function
// - Selector 0 is step plus direction active high; 5 is the active-low form.
// - Selector 1 is reverse/forward trains active high, reset default; 6 active low.
// - Selectors 2, 3, 4 decode quadrature at x1, x2, x4 active high.
// - Selectors 7, 8, 9 decode quadrature inverted, same timing.
// - Input pair meaning depends only on the current selector value.
// - Clear zeroes the deviation counter and disables the position loop.
// - Clear trigger is level high, level low, rising or falling edge.
// - Clear pulses shorter than the minimum are ignored.
// - Wake rising edge sends multi-turn count then initial incremental pulses.
// - Motor power stays off while wake is inactive.
// - Power request accepted only with wake active and encoder normal.
// - Power request enables main drive; otherwise only jog runs the motor.
`include "cppi_defines.svh"

module cppi_top
  import cppi_pkg::*;
#(
  parameter int CNT_W   = 32,
  parameter int CLR_CYC = `CPPI_CLR_MIN_CYC
) (
  // Clock and reset.
  input  wire logic             I_CLK,
  input  wire logic             I_RST,
  // Command pulse lines.
  input  wire logic             I_FEED_STEP_IN,
  input  wire logic             I_FORWARD_STEP_IN,
  // Configuration.
  input  wire logic [3:0]       I_STEP_FORMAT_SELECT,
  input  wire logic [1:0]       I_CLEAR_TRIGGER_SELECT,
  // Sequence inputs.
  input  wire logic             I_ERROR_COUNT_CLEAR,
  input  wire logic             I_ENCODER_WAKE,
  input  wire logic             I_POWER_REQUEST,
  input  wire logic             I_JOG_REQUEST,
  // Encoder side.
  input  wire logic             I_ENC_NORMAL,
  input  wire logic             I_ENC_SEND_DONE,
  // Outputs.
  output logic signed [CNT_W-1:0] O_DEVIATION,
  output logic                  O_POS_LOOP_EN,
  output logic                  O_MOTOR_POWER,
  output logic                  O_ENC_SEND_START,
  output logic                  O_FWD_CNT,
  output logic                  O_REV_CNT
);

  if (CNT_W < 8 || CLR_CYC < 1) begin : g_bad_params
    $error("cppi_top: bad parameters");
  end

  // ****************************************************************
  // Input capture
  // ****************************************************************
  logic      a_s_reg;
  logic      b_s_reg;
  logic      clr_s_reg;
  logic      clr_p_reg;
  logic      wake_s_reg;
  logic      wake_p_reg;
  cppi_fmt_t fmt;
  logic      fwd_cnt;
  logic      rev_cnt;

  // Codes above 9 are treated as the reset default.
  assign fmt = (I_STEP_FORMAT_SELECT > `CPPI_FMT_QUAD4_NEG) ? `CPPI_FMT_RESET
                                                              : I_STEP_FORMAT_SELECT;

  // register inputs first
  // The command lines keep sampling in reset, so an idle-high line shows no edge at release.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      a_s_reg    <= I_FEED_STEP_IN;
      b_s_reg    <= I_FORWARD_STEP_IN;
      clr_s_reg  <= 1'b0;
      clr_p_reg  <= 1'b0;
      wake_s_reg <= 1'b0;
      wake_p_reg <= 1'b0;
    end else begin
      a_s_reg    <= I_FEED_STEP_IN;
      b_s_reg    <= I_FORWARD_STEP_IN;
      clr_s_reg  <= I_ERROR_COUNT_CLEAR;
      clr_p_reg  <= clr_s_reg;
      wake_s_reg <= I_ENCODER_WAKE;
      wake_p_reg <= wake_s_reg;
    end
  end

  cppi_step_decode u_dec (
    .clk     (I_CLK),
    .rst     (I_RST),
    .fmt     (fmt),
    .line_a  (a_s_reg),
    .line_b  (b_s_reg),
    .fwd_cnt (fwd_cnt),
    .rev_cnt (rev_cnt)
  );

  // ****************************************************************
  // Clear qualification
  // ****************************************************************
  logic        clr_active;
  logic        clr_edge;
  logic        clr_level_mode;
  logic [31:0] clr_cnt_reg;
  logic        clr_qual;
  logic        edge_arm_reg;
  logic        clr_hold;

  always_comb begin
    unique case (I_CLEAR_TRIGGER_SELECT)
      `CPPI_CLR_LEVEL_HIGH: clr_active = clr_s_reg;
      `CPPI_CLR_LEVEL_LOW:  clr_active = ~clr_s_reg;
      `CPPI_CLR_RISING:     clr_active = clr_s_reg;
      `CPPI_CLR_FALLING:    clr_active = ~clr_s_reg;
    endcase
  end

  assign clr_level_mode = (I_CLEAR_TRIGGER_SELECT == `CPPI_CLR_LEVEL_HIGH) ||
                          (I_CLEAR_TRIGGER_SELECT == `CPPI_CLR_LEVEL_LOW);
  assign clr_edge = (I_CLEAR_TRIGGER_SELECT == `CPPI_CLR_RISING) ?
                    (clr_s_reg & ~clr_p_reg) :
                    (I_CLEAR_TRIGGER_SELECT == `CPPI_CLR_FALLING) ?
                    (~clr_s_reg & clr_p_reg) : 1'b0;
  assign clr_qual = (clr_cnt_reg >= 32'(CLR_CYC));

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      clr_cnt_reg <= 32'h0;
    end else if (!clr_active) begin
      clr_cnt_reg <= 32'h0;
    end else if (!clr_qual) begin
      clr_cnt_reg <= clr_cnt_reg + 32'h1;
    end
  end

  // An edge arms the clear; it fires once the new level has lasted long enough.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      edge_arm_reg <= 1'b0;
    end else if (clr_edge) begin
      edge_arm_reg <= 1'b1;
    end else if (!clr_active || clr_qual) begin
      edge_arm_reg <= 1'b0;
    end
  end

  assign clr_hold = clr_qual && (clr_level_mode || edge_arm_reg);

  // ****************************************************************
  // Deviation counter
  // ****************************************************************
  logic signed [CNT_W-1:0] dev_reg;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      dev_reg <= '0;
    end else if (clr_hold) begin
      dev_reg <= '0;
    end else if (fwd_cnt && !rev_cnt) begin
      dev_reg <= dev_reg + CNT_W'(1);
    end else if (rev_cnt && !fwd_cnt) begin
      dev_reg <= dev_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_FWD_CNT <= 1'b0;
      O_REV_CNT <= 1'b0;
    end else begin
      O_FWD_CNT <= fwd_cnt;
      O_REV_CNT <= rev_cnt;
    end
  end

  assign O_DEVIATION = dev_reg;

  // ****************************************************************
  // Encoder wake and power
  // ****************************************************************
  cppi_wake_e st_reg;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_reg           <= CPPI_ST_OFF;
      O_ENC_SEND_START <= 1'b0;
    end else begin
      O_ENC_SEND_START <= 1'b0;
      if (!wake_s_reg) begin
        st_reg <= CPPI_ST_OFF;
      end else begin
        unique case (st_reg)
          CPPI_ST_OFF: begin
            if (!wake_p_reg) begin
              st_reg           <= CPPI_ST_SEND;
              O_ENC_SEND_START <= 1'b1;
            end
          end
          CPPI_ST_SEND: begin
            if (I_ENC_SEND_DONE) begin
              st_reg <= CPPI_ST_WAIT_OK;
            end
          end
          CPPI_ST_WAIT_OK: begin
            if (I_ENC_NORMAL) begin
              st_reg <= CPPI_ST_READY;
            end
          end
          CPPI_ST_READY: begin
            if (!I_ENC_NORMAL) begin
              st_reg <= CPPI_ST_WAIT_OK;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_MOTOR_POWER <= 1'b0;
      O_POS_LOOP_EN <= 1'b0;
    end else begin
      O_MOTOR_POWER <= wake_s_reg && (st_reg == CPPI_ST_READY) && I_ENC_NORMAL &&
                       (I_POWER_REQUEST || I_JOG_REQUEST);
      O_POS_LOOP_EN <= !clr_hold && !(clr_qual && clr_edge);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_power_needs_wake: assert property (@(posedge I_CLK) disable iff (I_RST)
    !wake_s_reg |=> !O_MOTOR_POWER)
    else $error("motor power on without wake");

  a_power_needs_ready: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_MOTOR_POWER |-> $past(st_reg) == CPPI_ST_READY)
    else $error("motor power before encoder ready");

  a_power_needs_req: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_MOTOR_POWER |-> $past(I_POWER_REQUEST) || $past(I_JOG_REQUEST))
    else $error("motor power without request");

  a_wake_send_pulse: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st_reg == CPPI_ST_OFF && wake_s_reg && !wake_p_reg) |=>
      O_ENC_SEND_START ##1 !O_ENC_SEND_START)
    else $error("send start not one pulse on wake rise");

  a_clear_zeroes: assert property (@(posedge I_CLK) disable iff (I_RST)
    clr_hold |=> dev_reg == '0 && !O_POS_LOOP_EN)
    else $error("clear did not zero counter");

  a_short_clear_kept: assert property (@(posedge I_CLK) disable iff (I_RST)
    (clr_cnt_reg < 32'(CLR_CYC) && !fwd_cnt && !rev_cnt) |=> dev_reg == $past(dev_reg))
    else $error("short clear changed counter");

  a_count_up: assert property (@(posedge I_CLK) disable iff (I_RST)
    (fwd_cnt && !rev_cnt && !clr_hold) |=> dev_reg == $past(dev_reg) + CNT_W'(1))
    else $error("forward count missed");

  a_count_down: assert property (@(posedge I_CLK) disable iff (I_RST)
    (rev_cnt && !fwd_cnt && !clr_hold) |=> dev_reg == $past(dev_reg) - CNT_W'(1))
    else $error("reverse count missed");

  a_fwd_rev_train: assert property (@(posedge I_CLK) disable iff (I_RST)
    (fmt == `CPPI_FMT_FWD_REV_POS && b_s_reg && !$past(b_s_reg)) |-> fwd_cnt)
    else $error("forward train edge not counted");

  a_edge_clear_once: assert property (@(posedge I_CLK) disable iff (I_RST)
    (clr_hold && !clr_level_mode) |=> !clr_hold || clr_level_mode)
    else $error("edge clear fired twice");

  a_loop_idle_on: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!clr_hold && !clr_qual) |=> O_POS_LOOP_EN)
    else $error("position loop off without clear");

  a_send_needs_rise: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_ENC_SEND_START |-> $past(wake_s_reg) && !$past(wake_p_reg))
    else $error("send start without wake rise");

  a_power_off_unready: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st_reg != CPPI_ST_READY) |=> !O_MOTOR_POWER)
    else $error("motor power while encoder not ready");

  a_fwd_pulse_out: assert property (@(posedge I_CLK) disable iff (I_RST)
    fwd_cnt |=> O_FWD_CNT)
    else $error("forward count pulse not shown");

  a_rev_pulse_out: assert property (@(posedge I_CLK) disable iff (I_RST)
    rev_cnt |=> O_REV_CNT)
    else $error("reverse count pulse not shown");

endmodule : cppi_top

// ---- sim/cppi_host_model.sv ----
// **********
// Host controller and encoder model.
// **********
module cppi_host_model
  import cppi_pkg::*;
(
  // Clock and configuration.
  input  wire logic      clk,
  input  wire cppi_fmt_t fmt,
  // Sequence lines.
  input  wire logic      wake,
  input  wire logic      send_start,
  input  wire logic      enc_ok,
  // Outputs to the block.
  output logic           line_a,
  output logic           line_b,
  output logic           send_done,
  output logic           enc_normal
);
  timeunit 1ns;
  timeprecision 100ps;

  int   cnt  = 0;
  logic sent = 1'b0;

  initial begin
    line_a     = 1'b0;
    line_b     = 1'b0;
    send_done  = 1'b0;
    enc_normal = 1'b0;
  end

  task automatic move(input logic a, input logic b);
    logic inv;
    inv    = (fmt >= 4'h5) && (fmt <= 4'h9);
    line_a = a ^ inv;
    line_b = b ^ inv;
    repeat (4) @(posedge clk);
    #1;
  endtask : move

  always @(posedge clk) begin
    send_done <= #1 (cnt == 1);
    if (!wake) begin
      cnt  = 0;
      sent = 1'b0;
    end else if (send_start) begin
      cnt = 6;
    end else if (cnt > 0) begin
      if (cnt == 1) sent = 1'b1;
      cnt = cnt - 1;
    end
    enc_normal <= #1 wake && sent && enc_ok;
  end
endmodule : cppi_host_model

// ---- sim/tb.sv ----
module tb
  import cppi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CLR = 8;

  logic               clk    = 1'b0;
  logic               rst    = 1'b1;
  cppi_fmt_t          fmt    = 4'h1;
  logic [1:0]         sel    = 2'h0;
  logic               clr    = 1'b0;
  logic               wake   = 1'b0;
  logic               preq   = 1'b0;
  logic               jog    = 1'b0;
  logic               enc_ok = 1'b0;
  logic               line_a, line_b, send_done, enc_normal;
  logic signed [31:0] dev;
  logic               loop_en, power, send_start, fwd_cnt, rev_cnt;
  int                 n_errors = 0, n_checks = 0, nf = 0, nr = 0, cyc = 0;

  always #2.5 clk = ~clk;

  cppi_top #(.CNT_W(32), .CLR_CYC(CLR)) DUT (
    .I_CLK(clk), .I_RST(rst), .I_FEED_STEP_IN(line_a), .I_FORWARD_STEP_IN(line_b),
    .I_STEP_FORMAT_SELECT(fmt), .I_CLEAR_TRIGGER_SELECT(sel), .I_ERROR_COUNT_CLEAR(clr),
    .I_ENCODER_WAKE(wake), .I_POWER_REQUEST(preq), .I_JOG_REQUEST(jog),
    .I_ENC_NORMAL(enc_normal), .I_ENC_SEND_DONE(send_done), .O_DEVIATION(dev),
    .O_POS_LOOP_EN(loop_en), .O_MOTOR_POWER(power), .O_ENC_SEND_START(send_start),
    .O_FWD_CNT(fwd_cnt), .O_REV_CNT(rev_cnt));

  cppi_host_model host (
    .clk(clk), .fmt(fmt), .wake(wake), .send_start(send_start), .enc_ok(enc_ok),
    .line_a(line_a), .line_b(line_b), .send_done(send_done), .enc_normal(enc_normal));

  always @(posedge clk) begin
    if (fwd_cnt === 1'b1) nf++;
    if (rev_cnt === 1'b1) nr++;
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // **********
  // Helpers.
  // **********
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check_cnt(input string nm, input logic signed [31:0] e,
                           input logic signed [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_cnt

  task automatic check_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic do_reset();
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
  endtask : do_reset

  task automatic pulse_clear(input int n);
    logic act;
    act = (sel <= 2'h1);
    // clear held for the given width
    clr = act;
    tick(n);
    if (n > CLR) begin
      check_cnt("deviation in clear", 0, dev);
      if (sel[0] == 1'b0) check_bit("loop in clear", 1'b0, loop_en);
    end
    clr = ~act;
    tick(4);
  endtask : pulse_clear

  task automatic seq(input int cls, input bit fwd);
    case (cls)
      0: if (fwd) begin
        host.move(0, 1); host.move(1, 1); host.move(0, 1);
      end else begin
        host.move(0, 0); host.move(1, 0); host.move(0, 0);
      end
      1: if (fwd) begin
        host.move(0, 1); host.move(0, 0);
      end else begin
        host.move(1, 0); host.move(0, 0);
      end
      default: if (fwd) begin
        host.move(1, 0); host.move(1, 1); host.move(0, 1); host.move(0, 0);
      end else begin
        host.move(0, 1); host.move(1, 1); host.move(1, 0); host.move(0, 0);
      end
    endcase
  endtask : seq

  // **********
  // Scenarios.
  // **********
  task automatic test_formats();
    int n;
    int cls;
    // Code 10 is out of range and must act as the reset default.
    for (int f = 0; f < 11; f++) begin
      cls = (f > 9) ? 1 : f % 5;
      fmt = cppi_fmt_t'(f);
      sel = 2'h0;
      host.move(0, 0);
      do_reset();
      tick(6);
      check_bit("loop after reset", 1'b1, loop_en);
      check_bit("power after reset", 1'b0, power);
      check_cnt("deviation after reset", 0, dev);
      pulse_clear(CLR + 4);
      n  = (cls == 3) ? 2 : (cls == 4) ? 4 : 1;
      nf = 0;
      nr = 0;
      seq(cls, 1'b1);
      tick(4);
      check_cnt("deviation forward", n, dev);
      check_cnt("forward pulses", n, nf);
      pulse_clear(CLR - 2);
      check_cnt("deviation short clear", n, dev);
      seq(cls, 1'b0);
      tick(4);
      check_cnt("deviation reverse", 0, dev);
      check_cnt("reverse pulses", n, nr);
    end
    $display("test_formats done");
  endtask : test_formats

  task automatic test_clear_modes();
    fmt = 4'h4;
    host.move(0, 0);
    do_reset();
    tick(4);
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      clr = (s >= 2);
      tick(4);
      seq(4, 1'b1);
      tick(4);
      check_cnt("deviation before clear", 4, dev);
      pulse_clear(CLR + 4);
      check_cnt("deviation after clear", 0, dev);
    end
    $display("test_clear_modes done");
  endtask : test_clear_modes

  task automatic count_starts(input string nm);
    int ns;
    ns = 0;
    for (int k = 0; k < 10; k++) begin
      tick(1);
      if (send_start === 1'b1) ns++;
    end
    check_cnt(nm, 1, ns);
  endtask : count_starts

  task automatic test_wake();
    preq = 1'b1;
    tick(20);
    check_bit("power wake off", 1'b0, power);
    wake = 1'b1;
    count_starts("send start first");
    tick(30);
    check_bit("power encoder bad", 1'b0, power);
    enc_ok = 1'b1;
    tick(6);
    check_bit("power ready", 1'b1, power);
    preq = 1'b0;
    tick(4);
    check_bit("power no request", 1'b0, power);
    jog = 1'b1;
    tick(4);
    check_bit("power jog", 1'b1, power);
    jog  = 1'b0;
    preq = 1'b1;
    wake = 1'b0;
    tick(4);
    check_bit("power wake dropped", 1'b0, power);
    wake = 1'b1;
    count_starts("send start again");
    tick(20);
    check_bit("power wake again", 1'b1, power);
    $display("test_wake done");
  endtask : test_wake

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    do_reset();
    test_formats();
    test_clear_modes();
    test_wake();
    report_and_stop();
  end
endmodule : tb
